// ===== design/bse_exec.v
// Execution unit for bit set/clear, compare and increment/decrement/test with skip
`include "bse_defines.vh"

module bse_exec #(
  parameter BANK_W = 2,
  parameter ADDR_W = 8
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_valid,
  input wire [`BSE_OP_W-1:0] i_op,
  input wire [2:0] i_bit,
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_imm,
  input wire [BANK_W-1:0] i_bank,
  input wire [7:0] i_acc,
  input wire [7:0] i_mem_rdata,
  output wire o_ready,
  output reg o_mem_rd_en,
  output reg [BANK_W-1:0] o_mem_bank,
  output reg [ADDR_W-1:0] o_mem_addr,
  output reg o_mem_we,
  output reg [7:0] o_mem_wdata,
  output reg o_acc_we,
  output reg [7:0] o_acc_wdata,
  output reg o_flag_we,
  output reg o_zero_flag,
  output reg o_carry_flag,
  output reg o_skip,
  output reg o_done,
  output reg o_discard
);

  // Sequencer state, one-hot
  reg [`BSE_ST_W-1:0] state;
  // Next sequencer state
  reg [`BSE_ST_W-1:0] next_state;
  // Captured operation
  reg [`BSE_OP_W-1:0] op;
  // Captured bit index
  reg [2:0] bit_sel;
  // Captured immediate
  reg [7:0] imm;
  // Captured accumulator
  reg [7:0] acc;

  // One-hot state codes, taken from the shared header
  localparam [`BSE_ST_W-1:0] ST_IDLE = `BSE_ST_IDLE;
  localparam [`BSE_ST_W-1:0] ST_READ = `BSE_ST_READ;
  localparam [`BSE_ST_W-1:0] ST_EXEC = `BSE_ST_EXEC;
  localparam [`BSE_ST_W-1:0] ST_SKIP = `BSE_ST_SKIP;

  // Timing of one issued word, take edge as cycle 0:
  // cycle 1 read request, address and bank stand
  // cycle 2 memory byte must be on i_mem_rdata
  // cycle 3 done plus write, flag and skip strobes
  // Limitation: a pending skip waits for the next word,
  // so the core must keep issuing after a skip
  // Trade-off: memory is read even for the immediate
  // compare, which keeps one fixed sequence for all codes

  // Issue accepted in idle; in skip the arriving word is swallowed
  assign o_ready = state[0] | state[3];

  // Operand forced to bank zero for the bank-zero group
  // Decoded from the issue word, as the bank is latched then
  wire bank_zero_op = (i_op == `BSE_OP_BANK_ZERO_BIT_SET) |
                      (i_op == `BSE_OP_BANK_ZERO_BIT_CLEAR) |
                      (i_op == `BSE_OP_BANK_ZERO_TEST_LOW) |
                      (i_op == `BSE_OP_BANK_ZERO_TEST_HIGH);

  // Single-bit mask for the captured bit index
  wire [7:0] bit_mask = `BSE_ONE_BYTE << bit_sel;
  // Selected bit of the fetched byte
  wire bit_val = |(i_mem_rdata & bit_mask);
  // Compare operand: immediate or memory byte
  wire [7:0] cmp_opnd = (op == `BSE_OP_COMPARE_IMM) ? imm : i_mem_rdata;
  // Nine-bit difference; bit 8 set means a borrow occurred
  wire [8:0] cmp_diff = {1'b0, acc} - {1'b0, cmp_opnd};
  // Incremented memory byte, wrap intended
  wire [7:0] inc_val = i_mem_rdata + `BSE_ONE_BYTE;
  // Decremented memory byte, wrap intended
  wire [7:0] dec_val = i_mem_rdata - `BSE_ONE_BYTE;
  // Hazard: the byte is read raw, so the core
  // must hold it through the execute cycle

  // Results computed in the execute cycle
  // Memory write request
  reg next_mem_we;
  // Byte to write back
  reg [7:0] next_mem_wdata;
  // Accumulator write request
  reg next_acc_we;
  // Value for the accumulator
  reg [7:0] next_acc_wdata;
  // Flag update request, compares only
  reg next_flag_we;
  // Zero flag candidate
  reg next_zero;
  // Carry flag candidate
  reg next_carry;
  // Skip condition met
  reg next_skip;

  // Datapath decode; only meaningful while executing
  always @* begin
    // Defaults: no strobes, flags hold their value
    next_mem_we = 1'b0;
    next_mem_wdata = i_mem_rdata;
    next_acc_we = 1'b0;
    next_acc_wdata = acc;
    next_flag_we = 1'b0;
    next_zero = o_zero_flag;
    next_carry = o_carry_flag;
    next_skip = 1'b0;
    case (op)
      // Set one bit, others kept
      `BSE_OP_BIT_SET: begin
        next_mem_we = 1'b1;
        next_mem_wdata = i_mem_rdata | bit_mask;
      end
      // Clear one bit, others kept
      `BSE_OP_BIT_CLEAR: begin
        next_mem_we = 1'b1;
        next_mem_wdata = i_mem_rdata & ~bit_mask;
      end
      // Bank was forced to zero at issue
      `BSE_OP_BANK_ZERO_BIT_SET: begin
        next_mem_we = 1'b1;
        next_mem_wdata = i_mem_rdata | bit_mask;
      end
      // Bank was forced to zero at issue
      `BSE_OP_BANK_ZERO_BIT_CLEAR: begin
        next_mem_we = 1'b1;
        next_mem_wdata = i_mem_rdata & ~bit_mask;
      end
      // Compares never store the difference
      `BSE_OP_COMPARE_IMM: begin
        next_flag_we = 1'b1;
        next_zero = (cmp_diff[7:0] == `BSE_RST_BYTE);
        next_carry = ~cmp_diff[8];
        next_skip = (acc == cmp_opnd);
      end
      // Memory operand, same flag rules
      `BSE_OP_COMPARE_MEM: begin
        next_flag_we = 1'b1;
        next_zero = (cmp_diff[7:0] == `BSE_RST_BYTE);
        next_carry = ~cmp_diff[8];
        next_skip = (acc == cmp_opnd);
      end
      // Result to accumulator, memory untouched
      `BSE_OP_INC_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc_wdata = inc_val;
        next_skip = (inc_val == `BSE_RST_BYTE);
      end
      // Result written back into the byte
      `BSE_OP_INC_MEM: begin
        next_mem_we = 1'b1;
        next_mem_wdata = inc_val;
        next_skip = (inc_val == `BSE_RST_BYTE);
      end
      // Result to accumulator, memory untouched
      `BSE_OP_DEC_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc_wdata = dec_val;
        next_skip = (dec_val == `BSE_RST_BYTE);
      end
      // Result written back into the byte
      `BSE_OP_DEC_MEM: begin
        next_mem_we = 1'b1;
        next_mem_wdata = dec_val;
        next_skip = (dec_val == `BSE_RST_BYTE);
      end
      // Tests leave memory and flags alone
      `BSE_OP_TEST_LOW: begin
        next_skip = ~bit_val;
      end
      // Current bank, skip on a set bit
      `BSE_OP_TEST_HIGH: begin
        next_skip = bit_val;
      end
      // Bank zero, skip on a clear bit
      `BSE_OP_BANK_ZERO_TEST_LOW: begin
        next_skip = ~bit_val;
      end
      // Bank zero, skip on a set bit
      `BSE_OP_BANK_ZERO_TEST_HIGH: begin
        next_skip = bit_val;
      end
      // Unknown codes complete with no effect
      default: begin
        next_skip = 1'b0;
      end
    endcase
  end

  // Sequencing: idle -> read -> exec -> idle or skip
  always @* begin
    case (state)
      // Wait for an issued word
      ST_IDLE: begin
        next_state = i_valid ? ST_READ : ST_IDLE;
      end
      // Memory byte arrives in the next cycle
      ST_READ: begin
        next_state = ST_EXEC;
      end
      // A met skip condition adds the discard phase
      ST_EXEC: begin
        next_state = next_skip ? ST_SKIP : ST_IDLE;
      end
      // Waits for the next word and throws it away
      ST_SKIP: begin
        next_state = i_valid ? ST_IDLE : ST_SKIP;
      end
      // Recover from an illegal code
      default: begin
        next_state = `BSE_ST_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Idle after reset, ready for a word
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture operands at issue; a discarded word is never captured
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Neutral operands until the first word
      op <= `BSE_OP_BIT_SET;
      bit_sel <= 3'h0;
      imm <= `BSE_RST_BYTE;
      acc <= `BSE_RST_BYTE;
      o_mem_bank <= {BANK_W{1'b0}};
      o_mem_addr <= {ADDR_W{1'b0}};
    end else if (state[0] && i_valid) begin
      // Operands stay put until the next issue
      op <= i_op;
      bit_sel <= i_bit;
      imm <= i_imm;
      acc <= i_acc;
      // Bank zero group ignores the selected bank
      o_mem_bank <= bank_zero_op ? {BANK_W{1'b0}} : i_bank;
      o_mem_addr <= i_addr;
    end
  end

  // Registered one-cycle result strobes; held flags keep their value
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // All strobes low, data cleared
      o_mem_rd_en <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_wdata <= `BSE_RST_BYTE;
      o_acc_we <= 1'b0;
      o_acc_wdata <= `BSE_RST_BYTE;
      o_flag_we <= 1'b0;
      o_zero_flag <= 1'b0;
      o_carry_flag <= 1'b0;
      o_skip <= 1'b0;
      o_done <= 1'b0;
      o_discard <= 1'b0;
    end else begin
      // Strobes are single-cycle pulses
      // Read is issued for one cycle after capture
      o_mem_rd_en <= state[0] & i_valid;
      // Result strobes only leave the execute cycle
      o_mem_we <= state[2] & next_mem_we;
      o_acc_we <= state[2] & next_acc_we;
      o_flag_we <= state[2] & next_flag_we;
      o_skip <= state[2] & next_skip;
      o_done <= state[2];
      // Swallowed word: no write strobe fires for it
      o_discard <= state[3] & i_valid;
      if (state[2]) begin
        o_mem_wdata <= next_mem_wdata;
        o_acc_wdata <= next_acc_wdata;
        o_zero_flag <= next_zero;
        o_carry_flag <= next_carry;
      end
    end
  end

endmodule

// ===== design/bse_defines.vh
// Opcode codes, state codes and widths for the bit and skip execution block
`ifndef BSE_DEFINES_VH
`define BSE_DEFINES_VH

// Opcode field width
`define BSE_OP_W 4
// Operation codes presented on i_op
`define BSE_OP_BIT_SET 4'h0
`define BSE_OP_BIT_CLEAR 4'h1
`define BSE_OP_BANK_ZERO_BIT_SET 4'h2
`define BSE_OP_BANK_ZERO_BIT_CLEAR 4'h3
`define BSE_OP_COMPARE_IMM 4'h4
`define BSE_OP_COMPARE_MEM 4'h5
`define BSE_OP_INC_TO_ACC 4'h6
`define BSE_OP_INC_MEM 4'h7
`define BSE_OP_DEC_TO_ACC 4'h8
`define BSE_OP_DEC_MEM 4'h9
`define BSE_OP_TEST_LOW 4'hA
`define BSE_OP_TEST_HIGH 4'hB
`define BSE_OP_BANK_ZERO_TEST_LOW 4'hC
`define BSE_OP_BANK_ZERO_TEST_HIGH 4'hD

// One-hot state codes
`define BSE_ST_W 4
`define BSE_ST_IDLE 4'h1
`define BSE_ST_READ 4'h2
`define BSE_ST_EXEC 4'h4
`define BSE_ST_SKIP 4'h8

// Reset byte value and the unit byte used for increment, decrement and bit masks
`define BSE_RST_BYTE 8'h00
`define BSE_ONE_BYTE 8'h01

`endif

// ===== test/bse_exec_props.sv
// Checker of strobe timing and flag relations of the execution unit
module bse_exec_props (
  input wire i_clk,
  input wire i_nrst,
  input wire o_ready,
  input wire o_mem_rd_en,
  input wire o_mem_we,
  input wire o_acc_we,
  input wire o_flag_we,
  input wire o_zero_flag,
  input wire o_carry_flag,
  input wire o_skip,
  input wire o_done,
  input wire o_discard
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_done_after_read: assert property (o_mem_rd_en |-> !o_ready ##1 !o_ready ##1 o_done)
    else $error("done not two cycles after read");
  a_write_at_done: assert property (o_mem_we |-> o_done && !o_acc_we)
    else $error("write strobe out of place");
  a_acc_keeps_mem: assert property (o_acc_we |-> o_done && !o_mem_we && !o_flag_we)
    else $error("accumulator write with memory write");
  a_skip_then_wait: assert property (o_skip |-> o_done ##1 o_ready)
    else $error("skip not followed by wait");
  a_flags_held: assert property (!o_flag_we |-> $stable({o_zero_flag, o_carry_flag}))
    else $error("flags moved without update");
  a_skip_on_equal: assert property (o_flag_we |-> o_skip == o_zero_flag)
    else $error("compare skip differs from zero flag");
  a_equal_no_borrow: assert property (o_flag_we && o_zero_flag |-> o_carry_flag)
    else $error("equal compare with borrow");
  a_discard_is_nop: assert property (o_discard |-> !(o_mem_we || o_acc_we || o_flag_we || o_skip))
    else $error("discarded word had effects");
endmodule
bind bse_exec bse_exec_props u_props (.i_clk(i_clk), .i_nrst(i_nrst), .o_ready(o_ready),
  .o_mem_rd_en(o_mem_rd_en), .o_mem_we(o_mem_we), .o_acc_we(o_acc_we), .o_flag_we(o_flag_we),
  .o_zero_flag(o_zero_flag), .o_carry_flag(o_carry_flag), .o_skip(o_skip), .o_done(o_done),
  .o_discard(o_discard));

// ===== test/testbench.sv
// Self-checking bench of the bit and skip execution unit
`include "bse_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0;
  logic i_nrst = 0;
  logic i_valid = 0;
  logic [3:0] i_op = 4'h0;
  logic [2:0] i_bit = 3'h0;
  logic [1:0] i_bank = 2'h0;
  logic [7:0] i_addr = 8'h00, i_imm = 8'h00, i_acc = 8'h00, i_mem_rdata = 8'h00;
  wire o_ready, o_mem_rd_en, o_mem_we, o_acc_we, o_flag_we, o_zero_flag, o_carry_flag, o_skip, o_done, o_discard;
  wire [1:0] o_mem_bank;
  wire [7:0] o_mem_addr, o_mem_wdata, o_acc_wdata;
  int fails = 0, checked = 0, cycles = 0;
  bse_exec u_bse_exec (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_op(i_op), .i_bit(i_bit),
    .i_addr(i_addr), .i_imm(i_imm), .i_bank(i_bank), .i_acc(i_acc), .i_mem_rdata(i_mem_rdata),
    .o_ready(o_ready), .o_mem_rd_en(o_mem_rd_en), .o_mem_bank(o_mem_bank), .o_mem_addr(o_mem_addr),
    .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_acc_we(o_acc_we), .o_acc_wdata(o_acc_wdata),
    .o_flag_we(o_flag_we), .o_zero_flag(o_zero_flag), .o_carry_flag(o_carry_flag), .o_skip(o_skip),
    .o_done(o_done), .o_discard(o_discard));
  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;
  // Hang guard, about three times the expected run
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      report_and_stop;
    end
  end
  // Reference: {mem we, wdata, acc we, acc data, flag we, zero, carry, skip}
  function automatic logic [21:0] expect_res(input logic [3:0] op, input logic [2:0] b, input logic [7:0] imm,
    input logic [7:0] acc, input logic [7:0] m);
    logic [7:0] bm, opd, r;
    logic mw, aw, fw, z, c, sk;
    bm = 8'h01 << b;
    opd = (op == `BSE_OP_COMPARE_IMM) ? imm : m;
    r = (op < 4'h8) ? m + 8'h01 : m - 8'h01;
    mw = (op < 4'h4) || op == `BSE_OP_INC_MEM || op == `BSE_OP_DEC_MEM;
    aw = op == `BSE_OP_INC_TO_ACC || op == `BSE_OP_DEC_TO_ACC;
    fw = op == `BSE_OP_COMPARE_IMM || op == `BSE_OP_COMPARE_MEM;
    z = fw && acc == opd;
    c = fw && acc >= opd;
    sk = z || ((mw || aw) && op > 4'h5 && r == 8'h00);
    // Bit ops: even code sets, odd clears
    if (op < 4'h4) r = op[0] ? m & ~bm : m | bm;
    // Tests: skip when the bit equals the code's low bit
    if (op >= 4'hA && op <= 4'hD) sk = m[b] == op[0];
    return {mw, mw ? r : 8'h00, aw, aw ? r : 8'h00, fw, z, c, sk};
  endfunction
  // Single comparison of packed results
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Issue one word, serve the read, check results and any discard
  task automatic run_op(input logic [3:0] op, input logic [2:0] b, input logic [7:0] imm, input logic [7:0] acc,
    input logic [7:0] m);
    logic [21:0] ex;
    int n;
    ex = expect_res(op, b, imm, acc, m);
    @(posedge i_clk);
    i_valid <= 1;
    i_op <= op;
    i_bit <= b;
    i_imm <= imm;
    i_acc <= acc;
    i_mem_rdata <= m;
    i_addr <= 8'($urandom);
    i_bank <= 2'($urandom);
    @(posedge i_clk);
    i_valid <= 0;
    #1;
    // Unknown codes are only completed, read not checked
    if (op < 4'hE) cmp({o_mem_rd_en, o_mem_bank, o_mem_addr}, {1'b1, (op[3:1] == 3'h1 || op[3:1] == 3'h6) ? 2'h0 : i_bank, i_addr});
    for (n = 0; n < 6 && o_done !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    cmp({o_done, o_mem_we, o_mem_we ? o_mem_wdata : 8'h00, o_acc_we, o_acc_we ? o_acc_wdata : 8'h00, o_flag_we, o_flag_we && o_zero_flag, o_flag_we && o_carry_flag, o_skip}, {1'b1, ex});
    @(posedge i_clk);
    i_mem_rdata <= ~m;
    if (ex[0]) begin
      i_valid <= 1;
      i_op <= 4'($urandom);
      @(posedge i_clk);
      i_valid <= 0;
      #1 cmp({o_discard, o_mem_rd_en}, 2'b10);
    end
  endtask
  // Verdict and end of run
  task report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Corner table over every code, then random words
  initial begin
    void'($urandom(89));
    repeat (20) @(posedge i_clk);
    i_nrst <= 1;
    for (int k = 0; k < 32; k++) run_op(k[3:0], k[4] ? 3'h0 : 3'h7, 8'h01, 8'h01, k[4] ? 8'h01 : 8'hFF);
    repeat (300) run_op(4'($urandom % 14), 3'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    report_and_stop;
  end
endmodule
